/* logic/temp_adc_pkg.sv */
// Constants shared by the converter control block and its approximation engine.
// Assumes nothing beyond a SystemVerilog compiler.
package temp_adc_pkg;
  localparam int          ADC_BITS        = 10;
  localparam int          CTRL_BITS       = 8;
  localparam int          ADDR_BITS       = 3;
  localparam int          ADDR_ZERO_HI    = 7;
  localparam int          ADDR_ZERO_LO    = 3;
  localparam int          THR_CMP_LSB     = 2;
  localparam int          STEP_CYCLES_DEF = 4;
  localparam logic [7:0]  THR_RESET       = 8'h99;
  localparam logic [2:0]  ADDR_RESET      = 3'h0;
  localparam logic [2:0]  CH_TEMP         = 3'h0;
  localparam logic [2:0]  CH_IN1          = 3'h1;
  localparam logic [2:0]  CH_IN4          = 3'h4;
  localparam logic [2:0]  CH_REF          = 3'h7;
  localparam int          MUX_TEMP        = 0;
  localparam int          MUX_REF         = 5;
  localparam int          MUX_WIDTH       = 6;
  localparam int          SY_CONV         = 0;
  localparam int          SY_SCLK         = 1;
  localparam int          SY_RDWR         = 2;
  localparam int          SY_CS           = 3;
  localparam int          SY_SDI          = 4;
  localparam int          SY_WIDTH        = 5;
endpackage

/* logic/sar_engine.sv */
// Successive-approximation sequencer driving the capacitor DAC code.
// Assumes the comparator output is produced on mclk and needs no synchroniser.
`timescale 1ns/10ps
`default_nettype none
module sar_engine
  import temp_adc_pkg::*;
#(
  parameter int BITS        = ADC_BITS,
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire logic            clk_en,
  // Control
  input  wire logic            start,
  input  wire logic            comp_hi,
  // Results
  output logic [BITS-1:0]      dac_code,
  output logic [BITS-1:0]      result,
  output logic                 done
);
  localparam int IW = $clog2(BITS);
  localparam int CW = $clog2(STEP_CYCLES + 1);

  typedef struct packed {
    logic            active;
    logic [IW-1:0]   idx;
    logic [CW-1:0]   cnt;
    logic [BITS-1:0] code;
    logic [BITS-1:0] result;
    logic            done;
  } sar_t;

  sar_t st;
  sar_t next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.active         = 1'b1;
      next_st.idx            = IW'(BITS - 1);
      next_st.cnt            = '0;
      next_st.code           = '0;
      next_st.code[BITS-1]   = 1'b1;
    end else if (st.active) begin
      if (st.cnt == CW'(STEP_CYCLES - 1)) begin
        next_st.cnt = '0;
        // A trial bit stays only if the held input is not below the DAC level.
        if (!comp_hi) begin
          next_st.code[st.idx] = 1'b0;
        end
        if (st.idx == '0) begin
          next_st.active = 1'b0;
          next_st.done   = 1'b1;
          next_st.result = next_st.code;
        end else begin
          next_st.idx                = st.idx - 1'b1;
          next_st.code[st.idx - 1'b1] = 1'b1;
        end
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign dac_code = st.code;
  assign result   = st.result;
  assign done     = st.done;
endmodule // sar_engine
`default_nettype wire

/* logic/temp_adc_serial_control.sv */
// Digital control of a 10-bit converter with temperature channel and serial port.
// Assumes all pin inputs are asynchronous to mclk and a comparator clocked on mclk.
// Operation
// - Falling start edge begins 10-bit conversion
// - Hold during conversion, track again afterwards
// - Start low at conversion end powers down
// - Temperature result above threshold pulls alarm low
// - Rising read/write select releases alarm high
// - Output floats on select fall or CS rise
// - Out on falling clock, in on rising
// - Convert the channel held in address register
// - Shared pin driven by device only during reads
// - Four-channel part uses separate data pins
// - Serial port responds only with CS low
// - Busy high for whole conversion
// - Upper five zero loads address, else threshold
// - Decode temperature, inputs one-four, bandgap reference
`timescale 1ns/10ps
`default_nettype none
module temp_adc_serial_control
  import temp_adc_pkg::*;
#(
  parameter bit FOUR_CH     = 1'b1,
  parameter int STEP_CYCLES = STEP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  // Conversion pins
  input  wire logic                 conversion_start_n,
  output logic                      busy,
  output logic                      over_temp_alarm_n,
  output logic                      power_down,
  // Serial port pins
  input  wire logic                 sclk,
  input  wire logic                 rd_wr,
  input  wire logic                 cs_n,
  input  wire logic                 sdi,
  output logic                      sdo,
  output logic                      sdo_oe,
  // Analog front end
  input  wire logic                 comp_hi,
  output logic                      sample_hold,
  output logic [MUX_WIDTH-1:0]      analog_inputs,
  output logic [ADC_BITS-1:0]       dac_code
);
  typedef struct packed {
    logic [SY_WIDTH-1:0]  s1;
    logic [SY_WIDTH-1:0]  s2;
    logic [SY_WIDTH-1:0]  s3;
    logic                 start;
    logic                 busy;
    logic                 hold;
    logic                 pdown;
    logic                 alarm_n;
    logic [ADDR_BITS-1:0] addr;
    logic [CTRL_BITS-1:0] thr;
    logic [ADDR_BITS-1:0] conv_ch;
    logic [MUX_WIDTH-1:0] mux;
    logic [ADC_BITS-1:0]  rd_sh;
    logic                 sdo;
    logic                 sdo_oe;
    logic [CTRL_BITS-1:0] wr_sh;
    logic [2:0]           wr_cnt;
  } ctl_t;

  ctl_t st;
  ctl_t next_st;
  logic                done;
  logic [ADC_BITS-1:0] result;

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  function automatic logic [MUX_WIDTH-1:0] decode_ch(input logic [ADDR_BITS-1:0] a);
    logic [MUX_WIDTH-1:0] m;
    m = '0;
    if (a == CH_TEMP) begin
      m[MUX_TEMP] = 1'b1;
    end else if (a >= CH_IN1 && a <= CH_IN4) begin
      m[a] = 1'b1;
    end else if (a == CH_REF) begin
      m[MUX_REF] = 1'b1;
    end
    return m;
  endfunction

  logic cs_act;
  logic rw_rise;
  logic rw_fall;
  logic cs_rise;
  logic conv_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic over_thr;

  // Single-input variants have no chip select, so their port is always selected.
  assign cs_act    = FOUR_CH ? ~st.s2[SY_CS] : 1'b1;
  assign rw_rise   = fell(st.s2[SY_RDWR], st.s3[SY_RDWR]) & cs_act;
  assign rw_fall   = fell(st.s3[SY_RDWR], st.s2[SY_RDWR]);
  assign cs_rise   = FOUR_CH & fell(st.s2[SY_CS], st.s3[SY_CS]);
  assign conv_fall = fell(st.s3[SY_CONV], st.s2[SY_CONV]);
  assign sclk_rise = fell(st.s2[SY_SCLK], st.s3[SY_SCLK]);
  assign sclk_fall = fell(st.s3[SY_SCLK], st.s2[SY_SCLK]);
  assign byte_done = cs_act & ~st.s2[SY_RDWR] & sclk_rise & (st.wr_cnt == 3'h7);
  assign over_thr  = result[ADC_BITS-1:THR_CMP_LSB] > st.thr;

  always_comb begin
    next_st       = st;
    next_st.s1    = {sdi, cs_n, rd_wr, sclk, conversion_start_n};
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    next_st.start = 1'b0;
    if (fell(st.s2[SY_CONV], st.s3[SY_CONV])) begin
      next_st.pdown = 1'b0;
    end
    if (conv_fall && !st.busy) begin
      next_st.start   = 1'b1;
      next_st.busy    = 1'b1;
      next_st.hold    = 1'b1;
      next_st.pdown   = 1'b0;
      next_st.conv_ch = st.addr;
      next_st.mux     = decode_ch(st.addr);
    end
    // The alarm release comes first so that a result landing the same cycle wins.
    if (rw_rise) begin
      next_st.alarm_n = 1'b1;
    end
    if (done) begin
      next_st.busy = 1'b0;
      next_st.hold = 1'b0;
      if (!st.s2[SY_CONV]) begin
        next_st.pdown = 1'b1;
      end
      if (st.conv_ch == CH_TEMP) begin
        next_st.alarm_n = ~over_thr;
      end
    end
    if (rw_rise) begin
      next_st.rd_sh  = result;
      next_st.sdo    = result[ADC_BITS-1];
      next_st.sdo_oe = 1'b1;
    end else if (st.sdo_oe && sclk_fall) begin
      next_st.rd_sh = {st.rd_sh[ADC_BITS-2:0], 1'b0};
      next_st.sdo   = st.rd_sh[ADC_BITS-2];
    end
    if (rw_fall || cs_rise) begin
      next_st.sdo_oe = 1'b0;
    end
    if (rw_rise || cs_rise) begin
      next_st.wr_cnt = '0;
    end else if (cs_act && !st.s2[SY_RDWR] && sclk_rise) begin
      next_st.wr_sh  = {st.wr_sh[CTRL_BITS-2:0], st.s2[SY_SDI]};
      next_st.wr_cnt = st.wr_cnt + 3'h1;
      if (byte_done) begin
        if (next_st.wr_sh[ADDR_ZERO_HI:ADDR_ZERO_LO] == '0) begin
          next_st.addr = next_st.wr_sh[ADDR_BITS-1:0];
        end else begin
          next_st.thr = next_st.wr_sh;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st         <= '0;
      st.s1      <= '1;
      st.s2      <= '1;
      st.s3      <= '1;
      st.alarm_n <= 1'b1;
      st.addr    <= ADDR_RESET;
      st.thr     <= THR_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  sar_engine #(
    .BITS        (ADC_BITS),
    .STEP_CYCLES (STEP_CYCLES)
  ) u_sar (
    .mclk     (mclk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .start    (st.start),
    .comp_hi  (comp_hi),
    .dac_code (dac_code),
    .result   (result),
    .done     (done)
  );

  assign busy              = st.busy;
  assign over_temp_alarm_n = st.alarm_n;
  assign power_down        = st.pdown;
  assign sdo               = st.sdo;
  assign sdo_oe            = st.sdo_oe;
  assign sample_hold       = st.hold;
  assign analog_inputs     = st.mux;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_start;
    clk_en && conv_fall && !st.busy;
  endsequence

  sequence s_done;
    clk_en && done;
  endsequence

  property p_conv_begin;
    s_start |=> busy && sample_hold ##1 (clk_en ? busy : 1'b1);
  endproperty
  a_conv_begin: assert property (p_conv_begin) else $error("conversion did not start");

  property p_conv_end;
    s_done |=> !busy && !sample_hold;
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("sampler not back in track");

  property p_pdown;
    s_done ##0 !st.s2[SY_CONV] |=> power_down;
  endproperty
  a_pdown: assert property (p_pdown) else $error("no power-down after conversion");

  property p_alarm;
    s_done ##0 (st.conv_ch == CH_TEMP) |=> over_temp_alarm_n == !$past(over_thr);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm disagrees with threshold");

  property p_release;
    clk_en && rw_rise && !done |=> over_temp_alarm_n;
  endproperty
  a_release: assert property (p_release) else $error("alarm not released by read");

  property p_float;
    clk_en && (rw_fall || cs_rise) |=> !sdo_oe;
  endproperty
  a_float: assert property (p_float) else $error("data output still driven");

  property p_msb;
    clk_en && rw_rise |=> sdo_oe && sdo == $past(result[ADC_BITS-1]);
  endproperty
  a_msb: assert property (p_msb) else $error("read did not present the MSB");

  property p_addr;
    clk_en && byte_done && ({st.wr_sh[CTRL_BITS-2:0], st.s2[SY_SDI]} < 8'h08)
      |=> st.addr == $past({st.wr_sh[ADDR_BITS-2:0], st.s2[SY_SDI]}) && $stable(st.thr);
  endproperty
  a_addr: assert property (p_addr) else $error("control byte misrouted");

  property p_busy_hold;
    busy |-> sample_hold;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy without hold");

  property p_oe_read;
    sdo_oe |-> st.s2[SY_RDWR] || st.s3[SY_RDWR];
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("pin driven outside a read");
endmodule // temp_adc_serial_control
`default_nettype wire

/* bench/host_port_model.sv */
// Host side model driving the serial port and conversion start pins.
// Assumes the bench calls one task at a time; the serial clock idles high.
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  // Clock used to align pin changes
  input  wire logic mclk,
  // Pins toward the device
  output logic      sclk,
  output logic      rd_wr,
  output logic      cs_n,
  output logic      sdi,
  output logic      conversion_start_n,
  // Pin from the device
  input  wire logic sdo
);
  initial begin
    sclk = 1'b1;
    rd_wr = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b1;
    conversion_start_n = 1'b1;
  end
  // Edges are 40 ns apart, half of the 80 ns serial clock.
  task automatic write_byte(input logic [7:0] b, input logic sel);
    @(posedge mclk) #1;
    cs_n = ~sel;
    rd_wr = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #40 sclk = 1'b0;
      sdi = b[i];
      #40 sclk = 1'b1;
    end
    #40 cs_n = 1'b1;
    // Data line no longer carries a valid bit, so it is turned over.
    sdi = ~sdi;
    #40;
  endtask
  task automatic read_word(input logic sel, input logic by_cs, output logic [9:0] w);
    @(posedge mclk) #1;
    rd_wr = 1'b0;
    cs_n = ~sel;
    #40 rd_wr = 1'b1;
    #40 w[9] = sdo;
    // Sampled at the very end of the high phase, in the same step as the next falling edge.
    for (int i = 8; i >= 0; i--) begin
      sclk = 1'b0;
      #40 sclk = 1'b1;
      #40 w[i] = sdo;
    end
    if (by_cs) begin
      cs_n = 1'b1;
    end else begin
      rd_wr = 1'b0;
    end
    #40;
  endtask
  task automatic start_conv(input logic keep_low);
    @(posedge mclk) #1;
    conversion_start_n = 1'b0;
    #50 conversion_start_n = ~keep_low;
  endtask
  task automatic release_start();
    @(posedge mclk) #1;
    conversion_start_n = 1'b1;
  endtask
endmodule // host_port_model
`default_nettype wire

/* bench/temp_adc_serial_control_tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes an ideal comparator: the input level is a value set by each scenario.
`timescale 1ns/10ps
`default_nettype none
module temp_adc_serial_control_tb_top
  import temp_adc_pkg::*;
;
  localparam int STEPS = 2;
  logic                 mclk, nrst, clk_en, comp_hi;
  logic                 sclk, rd_wr, cs_n, sdi, conversion_start_n;
  logic                 busy, over_temp_alarm_n, power_down, sdo, sdo_oe, sample_hold;
  logic [MUX_WIDTH-1:0] analog_inputs;
  logic [ADC_BITS-1:0]  dac_code, vin;
  int                   errors, total_checks;
  logic                 sdo_pin;

  assign comp_hi = (vin >= dac_code);
  // A released data pin reads as the inverse of the last bit, so a late sample shows up.
  assign sdo_pin = sdo_oe ? sdo : ~sdo;
  temp_adc_serial_control #(.FOUR_CH(1'b1), .STEP_CYCLES(STEPS)) dut_u (
    .mclk, .nrst, .clk_en, .conversion_start_n, .busy, .over_temp_alarm_n,
    .power_down, .sclk, .rd_wr, .cs_n, .sdi, .sdo, .sdo_oe, .comp_hi,
    .sample_hold, .analog_inputs, .dac_code
  );
  host_port_model host_u (
    .mclk, .sclk, .rd_wr, .cs_n, .sdi, .conversion_start_n, .sdo (sdo_pin)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic lvl, input int limit, output int n);
    n = 0;
    while (busy !== lvl && n < limit) begin
      @(posedge mclk) #1;
      n++;
    end
    if (busy !== lvl) begin
      errors++;
      finish_test();
    end
  endtask

  // One conversion at level v, optionally followed by a read of the result.
  task automatic convert(input logic [9:0] v, input logic low, input logic [5:0] mux,
                         input logic alarm, input logic rd);
    int n;
    logic [9:0] w;
    vin = v;
    host_u.start_conv(low);
    wait_busy(1'b1, 10, n);
    check(sample_hold, 1'b1);
    check(analog_inputs, mux);
    check(dac_code, 10'h200);
    wait_busy(1'b0, 10 * STEPS + 10, n);
    check(n >= 10 * STEPS, 1'b1);
    check({sample_hold, power_down, over_temp_alarm_n}, {1'b0, low, alarm});
    if (rd) begin
      host_u.read_word(1'b1, 1'b0, w);
      check(w, v);
      check({sdo_oe, over_temp_alarm_n}, 2'b01);
    end
  endtask

  task automatic chan_scan();
    logic [2:0] ch [6];
    logic [5:0] mx [6];
    ch = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
    mx = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h01};
    // Default address and threshold first, at full scale.
    convert(10'h3ff, 1'b0, 6'h01, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      host_u.write_byte({5'h00, ch[i]}, 1'b1);
      convert(10'h015 + 10'(i * 100), 1'b0, mx[i], 1'b1, 1'b1);
    end
  endtask

  task automatic power_case();
    convert(10'h2aa, 1'b1, 6'h01, 1'b0, 1'b0);
    host_u.release_start();
    repeat (6) @(posedge mclk);
    #1 check(power_down, 1'b0);
  endtask

  task automatic alarm_case();
    logic [9:0] w;
    host_u.write_byte(8'h40, 1'b1);
    host_u.write_byte(8'h02, 1'b0);
    convert(10'h104, 1'b0, 6'h01, 1'b0, 1'b0);
    host_u.read_word(1'b0, 1'b0, w);
    check({sdo_oe, over_temp_alarm_n}, 2'b00);
    host_u.read_word(1'b1, 1'b1, w);
    check({w, sdo_oe, over_temp_alarm_n}, {10'h104, 2'b01});
    convert(10'h103, 1'b0, 6'h01, 1'b1, 1'b1);
  endtask

  initial begin
    errors = 0;
    total_checks = 0;
    clk_en = 1'b1;
    vin = 10'h000;
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge mclk);
    #1 check({busy, over_temp_alarm_n, power_down, sdo_oe, sample_hold}, 5'h08);
    chan_scan();
    power_case();
    alarm_case();
    finish_test();
  end
endmodule // temp_adc_serial_control_tb_top
`default_nettype wire
